//--- rtl/wim_pkg.sv
package wim_pkg;
	localparam int unsigned CLK_PERIOD_NS   = 50;
	localparam int unsigned SHORT_FILTER_NS = 16000;
	localparam int unsigned LONG_FILTER_NS  = 64000;
	localparam logic [10:0] SHORT_FILTER_CYC =
		11'((SHORT_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [10:0] LONG_FILTER_CYC =
		11'((LONG_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	localparam logic [7:0] OFS_WAKE_EN   = 8'h00;
	localparam logic [7:0] OFS_PULL      = 8'h04;
	localparam logic [7:0] OFS_FILT      = 8'h08;
	localparam logic [7:0] OFS_EVT       = 8'h0c;
	localparam logic [7:0] OFS_ALT_EVT   = 8'h10;
	localparam logic [7:0] OFS_LEVEL     = 8'h14;

	localparam int unsigned ALT_EN_LSB  = 3;
	localparam int unsigned MEAS_EN_BIT = 7;
	localparam logic [7:0] WAKE_EN_MASK = 8'h9f;
	localparam logic [7:0] WAKE_EN_RST  = 8'h00;
	localparam logic [5:0] PULL_RST     = 6'h00;
	localparam logic [5:0] FILT_RST     = 6'h00;

	localparam logic [1:0] PULL_NONE = 2'h0;
	localparam logic [1:0] PULL_DOWN = 2'h1;
	localparam logic [1:0] PULL_UP   = 2'h2;
	localparam logic [1:0] PULL_AUTO = 2'h3;
	localparam logic [1:0] FILT_STATIC_SHORT = 2'h0;
	localparam logic [1:0] FILT_STATIC_LONG  = 2'h1;
	localparam logic [1:0] FILT_CYCLIC_ONE   = 2'h2;
	localparam logic [1:0] FILT_CYCLIC_TWO   = 2'h3;

	typedef enum logic [1:0] {
		mode_normal,
		mode_stop,
		mode_sleep,
		mode_failsafe
	} wim_mode_type;

	// returns {pull_up, pull_down}
	function automatic logic [1:0] pull_decode(input logic [1:0] sel,
		input logic level);
		logic [1:0] r;
		r = 2'h0;
		unique case (sel)
			PULL_NONE: r = 2'h0;
			PULL_DOWN: r = 2'h1;
			PULL_UP:   r = 2'h2;
			PULL_AUTO: r = level ? 2'h2 : 2'h1;
		endcase
		return r;
	endfunction
endpackage

//--- rtl/wim_chan_if.sv
`timescale 1ns/1ps
interface wim_chan_if;
	logic level;
	logic active;
	logic long_sel;
	logic event_p;
	logic filt_level;
	modport filt (
		input  level,
		input  active,
		input  long_sel,
		output event_p,
		output filt_level
	);
	modport user (
		output level,
		output active,
		output long_sel,
		input  event_p,
		input  filt_level
	);
endinterface

//--- rtl/wim_sync.sv
`timescale 1ns/1ps
module wim_sync #(
	parameter int unsigned WIDTH = 5
) (
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] sync_r;
	logic [WIDTH-1:0] sync_nxt;

	always_comb
	begin
		meta_nxt = din;
		sync_nxt = meta_r;
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			meta_r <= '0;
			sync_r <= '0;
		end
		else if (ce)
		begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign dout = sync_r;
endmodule

//--- rtl/wim_filter.sv
`timescale 1ns/1ps
module wim_filter (
	input  wire logic  sys_clk,
	input  wire logic  nrst,
	input  wire logic  ce,
	wim_chan_if.filt   ch
);
	logic [10:0] cnt_r;
	logic [10:0] cnt_nxt;
	logic        stable_r;
	logic        stable_nxt;
	logic        primed_r;
	logic        primed_nxt;
	logic        event_r;
	logic        event_nxt;
	logic [10:0] limit;

	always_comb
	begin
		limit = ch.long_sel ? wim_pkg::LONG_FILTER_CYC
			: wim_pkg::SHORT_FILTER_CYC;
		cnt_nxt = cnt_r;
		stable_nxt = stable_r;
		primed_nxt = primed_r;
		event_nxt = 1'b0;
		if (!ch.active)
			cnt_nxt = 11'h000;
		else if (!primed_r)
		begin
			// first look after reset adopts the level, no false edge
			stable_nxt = ch.level;
			primed_nxt = 1'b1;
			cnt_nxt = 11'h000;
		end
		else if (ch.level == stable_r)
			cnt_nxt = 11'h000;
		else if (cnt_r == limit - 11'h001)
		begin
			stable_nxt = ch.level;
			event_nxt = 1'b1;
			cnt_nxt = 11'h000;
		end
		else
			cnt_nxt = cnt_r + 11'h001;
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_r <= 11'h000;
			stable_r <= 1'b0;
			primed_r <= 1'b0;
			event_r <= 1'b0;
		end
		else if (ce)
		begin
			cnt_r <= cnt_nxt;
			stable_r <= stable_nxt;
			primed_r <= primed_nxt;
			event_r <= event_nxt;
		end
	end

	assign ch.event_p = event_r;
	assign ch.filt_level = stable_r;

	chk_accept_span: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		$rose(event_r) |-> $past(cnt_r) == $past(limit) - 11'h001)
	else $error("edge accepted before filter time");

	chk_both_edges: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		$rose(event_r) |-> stable_r != $past(stable_r))
	else $error("accepted edge did not change level");
endmodule

//--- rtl/wim_top.sv
`timescale 1ns/1ps
module wim_top (
	input  wire logic                 sys_clk,
	input  wire logic                 nrst,
	input  wire logic                 ce,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic [2:0]           wake_pin_in,
	input  wire logic [1:0]           alt_wake_in,
	input  wire logic                 timer_one_on,
	input  wire logic                 timer_two_on,
	input  wire wim_pkg::wim_mode_type sbc_mode,
	input  wire logic                 sleep_cmd,
	output logic      [2:0]           pull_up_en,
	output logic      [2:0]           pull_down_en,
	output logic                      measure_switch,
	output logic                      wake_int,
	output logic                      wake_up_req,
	output logic                      serial_fail_set,
	output logic                      restart_req
);
	logic [4:0]  sync_lvl;
	logic [7:0]  wake_en_r;
	logic [7:0]  wake_en_nxt;
	logic [5:0]  pull_cfg_r;
	logic [5:0]  pull_cfg_nxt;
	logic [5:0]  filt_cfg_r;
	logic [5:0]  filt_cfg_nxt;
	logic [2:0]  evt_r;
	logic [2:0]  evt_nxt;
	logic [1:0]  alt_evt_r;
	logic [1:0]  alt_evt_nxt;
	logic [2:0]  level_r;
	logic [2:0]  level_nxt;
	logic [4:0]  win_r;
	logic [4:0]  win_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic        pready_r;
	logic        pready_nxt;
	logic        pslverr_r;
	logic        pslverr_nxt;
	logic [2:0]  pull_up_r;
	logic [2:0]  pull_up_nxt;
	logic [2:0]  pull_dn_r;
	logic [2:0]  pull_dn_nxt;
	logic        switch_r;
	logic        switch_nxt;
	logic        int_r;
	logic        int_nxt;
	logic        wake_r;
	logic        wake_nxt;
	logic        fail_r;
	logic        fail_nxt;
	logic        meas_en;
	logic [2:0]  gate;
	logic [4:0]  active;
	logic [4:0]  chan_evt;
	logic        setup_ph;
	logic        wr_acc;
	logic [2:0]  evt_set;
	logic [1:0]  alt_set;
	logic        awake_mode;

	wim_chan_if chan[5] ();

	wim_sync #(
		.WIDTH (5)
	) u_sync (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.ce      (ce),
		.din     ({alt_wake_in, wake_pin_in}),
		.dout    (sync_lvl)
	);

	assign meas_en = wake_en_r[wim_pkg::MEAS_EN_BIT];
	assign gate = {1'b0, meas_en, meas_en};
	assign awake_mode = (sbc_mode == wim_pkg::mode_normal)
		|| (sbc_mode == wim_pkg::mode_stop);

	// cyclic windows come from the timers; the supply they also drive is
	// software's business, so an unpowered sensor just reads its idle level
	always_comb
	begin
		active = 5'h00;
		for (int i = 0; i < 3; i++)
		begin
			unique case (filt_cfg_r[2*i +: 2])
				wim_pkg::FILT_STATIC_SHORT: active[i] = !gate[i];
				wim_pkg::FILT_STATIC_LONG:  active[i] = !gate[i];
				wim_pkg::FILT_CYCLIC_ONE:
					active[i] = !gate[i] && timer_one_on;
				wim_pkg::FILT_CYCLIC_TWO:
					active[i] = !gate[i] && timer_two_on;
			endcase
		end
		// alt channels run static whenever their enable bit is set
		active[3] = wake_en_r[wim_pkg::ALT_EN_LSB];
		active[4] = wake_en_r[wim_pkg::ALT_EN_LSB+1];
	end

	for (genvar i = 0; i < 3; i++)
	begin : g_wake
		assign chan[i].level = sync_lvl[i];
		assign chan[i].active = active[i];
		assign chan[i].long_sel =
			filt_cfg_r[2*i +: 2] == wim_pkg::FILT_STATIC_LONG;
		assign chan_evt[i] = chan[i].event_p;
		wim_filter u_filt (
			.sys_clk (sys_clk),
			.nrst    (nrst),
			.ce      (ce),
			.ch      (chan[i])
		);
	end

	for (genvar j = 0; j < 2; j++)
	begin : g_alt
		assign chan[3+j].level = sync_lvl[3+j];
		assign chan[3+j].active = active[3+j];
		assign chan[3+j].long_sel = 1'b0;
		assign chan_evt[3+j] = chan[3+j].event_p;
		wim_filter u_filt (
			.sys_clk (sys_clk),
			.nrst    (nrst),
			.ce      (ce),
			.ch      (chan[3+j])
		);
	end

	assign setup_ph = psel && !penable;
	assign wr_acc = psel && penable && pready_r && pwrite;
	assign evt_set = chan_evt[2:0] & wake_en_r[2:0] & ~gate;
	assign alt_set = chan_evt[4:3];

	// register file and bus answer; zero-wait, read data captured in setup
	always_comb
	begin
		wake_en_nxt = wake_en_r;
		pull_cfg_nxt = pull_cfg_r;
		filt_cfg_nxt = filt_cfg_r;
		prdata_nxt = prdata_r;
		pslverr_nxt = 1'b0;
		pready_nxt = setup_ph;
		if (setup_ph)
		begin
			pslverr_nxt = 1'b0;
			unique case (paddr)
				wim_pkg::OFS_WAKE_EN: prdata_nxt = {24'h0, wake_en_r};
				wim_pkg::OFS_PULL:    prdata_nxt = {26'h0, pull_cfg_r};
				wim_pkg::OFS_FILT:    prdata_nxt = {26'h0, filt_cfg_r};
				wim_pkg::OFS_EVT:     prdata_nxt = {29'h0, evt_r};
				wim_pkg::OFS_ALT_EVT: prdata_nxt = {30'h0, alt_evt_r};
				wim_pkg::OFS_LEVEL:   prdata_nxt = {29'h0, level_r};
				default:
				begin
					prdata_nxt = 32'h0;
					pslverr_nxt = 1'b1;
				end
			endcase
		end
		// pin one/two settings still take writes under measurement
		if (wr_acc)
		begin
			unique case (paddr)
				wim_pkg::OFS_WAKE_EN:
					wake_en_nxt = pwdata[7:0] & wim_pkg::WAKE_EN_MASK;
				wim_pkg::OFS_PULL: pull_cfg_nxt = pwdata[5:0];
				wim_pkg::OFS_FILT: filt_cfg_nxt = pwdata[5:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wake_en_r <= wim_pkg::WAKE_EN_RST;
			pull_cfg_r <= wim_pkg::PULL_RST;
			filt_cfg_r <= wim_pkg::FILT_RST;
			prdata_r <= 32'h0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else if (ce)
		begin
			wake_en_r <= wake_en_nxt;
			pull_cfg_r <= pull_cfg_nxt;
			filt_cfg_r <= filt_cfg_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// status flags, level view, pin controls and event signalling
	always_comb
	begin
		// set beats a same-cycle write-one-to-clear
		evt_nxt = evt_r | evt_set;
		alt_evt_nxt = alt_evt_r | alt_set;
		if (wr_acc && paddr == wim_pkg::OFS_EVT)
			evt_nxt = (evt_r & ~pwdata[2:0]) | evt_set;
		if (wr_acc && paddr == wim_pkg::OFS_ALT_EVT)
			alt_evt_nxt = (alt_evt_r & ~pwdata[1:0]) | alt_set;
		win_nxt = active;
		level_nxt = level_r;
		pull_up_nxt = 3'h0;
		pull_dn_nxt = 3'h0;
		for (int k = 0; k < 3; k++)
		begin
			if (awake_mode && !gate[k])
			begin
				if (!filt_cfg_r[2*k+1])
					level_nxt[k] = sync_lvl[k];
				else if (win_r[k] && !active[k])
					level_nxt[k] = sync_lvl[k];
			end
			if (!gate[k])
				{pull_up_nxt[k], pull_dn_nxt[k]} =
					wim_pkg::pull_decode(pull_cfg_r[2*k +: 2], sync_lvl[k]);
		end
		switch_nxt = meas_en && sbc_mode == wim_pkg::mode_normal;
		int_nxt = (|evt_set || |alt_set) && awake_mode;
		wake_nxt = (|evt_set || |alt_set) && !awake_mode;
		fail_nxt = sleep_cmd && meas_en && !wake_en_r[2]
			&& |wake_en_r[1:0];
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			evt_r <= 3'h0;
			alt_evt_r <= 2'h0;
			level_r <= 3'h0;
			win_r <= 5'h00;
			pull_up_r <= 3'h0;
			pull_dn_r <= 3'h0;
			switch_r <= 1'b0;
			int_r <= 1'b0;
			wake_r <= 1'b0;
			fail_r <= 1'b0;
		end
		else if (ce)
		begin
			evt_r <= evt_nxt;
			alt_evt_r <= alt_evt_nxt;
			level_r <= level_nxt;
			win_r <= win_nxt;
			pull_up_r <= pull_up_nxt;
			pull_dn_r <= pull_dn_nxt;
			switch_r <= switch_nxt;
			int_r <= int_nxt;
			wake_r <= wake_nxt;
			fail_r <= fail_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign pull_up_en = pull_up_r;
	assign pull_down_en = pull_dn_r;
	assign measure_switch = switch_r;
	assign wake_int = int_r;
	assign wake_up_req = wake_r;
	assign serial_fail_set = fail_r;
	assign restart_req = fail_r;

	chk_switch_open_lowpwr: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		ce && sbc_mode != wim_pkg::mode_normal |=> !measure_switch)
	else $error("measure switch closed outside normal mode");

	chk_switch_closed: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		ce && meas_en && sbc_mode == wim_pkg::mode_normal |=> measure_switch)
	else $error("measure switch not closed");

	chk_meas_pulls_off: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		ce && meas_en
		|=> pull_up_en[1:0] == 2'h0 && pull_down_en[1:0] == 2'h0)
	else $error("pin one/two pull active under measurement");

	chk_auto_pull_high: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		ce && pull_cfg_r[5:4] == wim_pkg::PULL_AUTO && sync_lvl[2]
		|=> pull_up_en[2] && !pull_down_en[2])
	else $error("auto pull did not follow high level");

	chk_flag_sticky: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		ce && !(wr_acc && paddr == wim_pkg::OFS_EVT)
		|=> (evt_r & $past(evt_r)) == $past(evt_r))
	else $error("wake flag lost without clear");

	chk_flag_enabled: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		$rose(evt_r[0]) |-> $past(wake_en_r[0]) && $past(chan_evt[0])
			&& !$past(meas_en))
	else $error("flag set without enabled edge");

	chk_int_mode: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		$rose(wake_int) |-> $past(awake_mode) && !wake_up_req)
	else $error("interrupt raised in a low-power mode");

	chk_sleep_fail: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		ce && sleep_cmd && meas_en && !wake_en_r[2] && wake_en_r[1:0] != 2'h0
		|=> serial_fail_set && restart_req)
	else $error("sleep with gated sources not refused");

	chk_gate_status: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		ce && meas_en && !(wr_acc && paddr == wim_pkg::OFS_EVT)
		|=> evt_r[1:0] == $past(evt_r[1:0])
			&& level_r[1:0] == $past(level_r[1:0]))
	else $error("pin one/two status moved under measurement");
endmodule

//--- dv/wim_switch_model.sv
`timescale 1ns/1ps
module wim_switch_model (
	input  wire logic       sys_clk,
	input  wire logic [2:0] sw_on,
	input  wire logic [2:0] sw_lvl,
	input  wire logic [2:0] pull_up_en,
	input  wire logic [2:0] pull_down_en,
	output logic      [2:0] pin
);
	logic [2:0] float_r = 3'h0;

	// an open unpulled pin wanders, so a stale level never looks valid
	always @(posedge sys_clk)
		float_r <= ~float_r;

	always_comb
		for (int i = 0; i < 3; i++)
			pin[i] = sw_on[i] ? sw_lvl[i] : pull_up_en[i] ? 1'b1 :
				pull_down_en[i] ? 1'b0 : float_r[i];
endmodule

//--- dv/test_wake_input_monitor.sv
`timescale 1ns/1ps
module test_wake_input_monitor;
	logic                  sys_clk;
	logic                  nrst    = 1'b0;
	logic                  ce      = 1'b1;
	logic                  psel    = 1'b0;
	logic                  penable = 1'b0;
	logic                  pwrite  = 1'b0;
	logic [7:0]            paddr   = 8'h00;
	logic [31:0]           pwdata  = 32'h0;
	logic [31:0]           prdata;
	logic                  pready;
	logic                  pslverr;
	logic [2:0]            pin;
	logic [1:0]            alt     = 2'h0;
	logic                  t_one   = 1'b0;
	logic                  t_two   = 1'b0;
	wim_pkg::wim_mode_type mode    = wim_pkg::mode_normal;
	logic                  slp     = 1'b0;
	logic [2:0]            pu;
	logic [2:0]            pd;
	logic                  msw;
	logic                  w_int;
	logic                  w_up;
	logic                  s_fail;
	logic                  rst_req;
	logic [2:0]            sw_on   = 3'h7;
	logic [2:0]            sw_lvl  = 3'h0;
	logic [5:0]            cfg;
	logic [31:0]           rd_d;
	logic                  rd_e;
	int                    err_count = 0;
	int                    compares  = 0;
	int                    n_int     = 0;
	int                    n_up      = 0;
	int                    n_fail    = 0;
	int                    n_rst     = 0;
	int                    n_mark    = 0;

	wim_top u_wim_top (
		.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .wake_pin_in(pin), .alt_wake_in(alt),
		.timer_one_on(t_one), .timer_two_on(t_two), .sbc_mode(mode),
		.sleep_cmd(slp), .pull_up_en(pu), .pull_down_en(pd),
		.measure_switch(msw), .wake_int(w_int), .wake_up_req(w_up),
		.serial_fail_set(s_fail), .restart_req(rst_req)
	);

	wim_switch_model u_wim_switch_model (
		.sys_clk(sys_clk), .sw_on(sw_on), .sw_lvl(sw_lvl),
		.pull_up_en(pu), .pull_down_en(pd), .pin(pin)
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// outputs are one-cycle pulses, so count them every edge
	always @(posedge sys_clk)
	begin
		n_int  += int'(w_int === 1'b1);
		n_up   += int'(w_up === 1'b1);
		n_fail += int'(s_fail === 1'b1);
		n_rst  += int'(rst_req === 1'b1);
	end

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
			@(posedge sys_clk);
		rd_d = prdata;
		rd_e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk("read data", e, rd_d);
		chk("slave error", 32'(a > 8'h14), rd_e);
	endtask

	// returns {up, down} for three pins
	function automatic logic [5:0] pull_exp(input logic [5:0] c,
		input logic [2:0] l);
		logic [5:0] r;
		for (int i = 0; i < 3; i++)
		begin
			r[i+3] = c[2*i+1] & (~c[2*i] | l[i]);
			r[i]   = c[2*i] & (~c[2*i+1] | ~l[i]);
		end
		return r;
	endfunction

	task automatic pulse_sleep;
		slp <= 1'b1;
		cyc(1);
		slp <= 1'b0;
		cyc(3);
	endtask

	task automatic give_verdict;
		$display("compares %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		cyc(30000);
		$display("Error watchdog expected end seen hang");
		err_count++;
		give_verdict;
	end

	initial
	begin
		rd_d = $urandom(32'h0625f96c);
		cyc(10);
		nrst <= 1'b1;
		for (int a = 0; a <= 24; a += 4)
			rd(8'(a), 32'h0);
		$display("reset test done");
		for (int k = 0; k < 8; k++)
		begin
			cfg = 6'($urandom);
			cfg[1:0] = 2'(k);
			sw_lvl <= 3'($urandom);
			wr(8'h04, {26'h0, cfg});
			cyc(5);
			chk("pulls", 32'(pull_exp(cfg, sw_lvl)), 32'({pu, pd}));
		end
		$display("pull test done");
		sw_lvl <= 3'h0;
		wr(8'h04, 32'h20);
		wr(8'h08, 32'h04);
		wr(8'h00, 32'h03);
		cyc(400);
		sw_lvl[0] <= 1'b1;
		cyc($urandom_range(250, 50));
		sw_lvl[0] <= 1'b0;
		cyc(400);
		rd(8'h0c, 32'h0);
		sw_lvl[0] <= 1'b1;
		cyc(400);
		rd(8'h0c, 32'h1);
		cyc(100);
		rd(8'h0c, 32'h1);
		wr(8'h0c, 32'h1);
		sw_lvl[0] <= 1'b0;
		cyc(400);
		rd(8'h0c, 32'h1);
		wr(8'h0c, 32'h1);
		sw_lvl[1] <= 1'b1;
		cyc(400);
		sw_lvl[1] <= 1'b0;
		cyc(1400);
		rd(8'h0c, 32'h0);
		sw_lvl[1] <= 1'b1;
		cyc(1400);
		rd(8'h0c, 32'h2);
		wr(8'h0c, 32'h2);
		// pin three left open, its pull-up lifts it
		sw_on[2] <= 1'b0;
		cyc(400);
		rd(8'h0c, 32'h0);
		rd(8'h14, 32'h6);
		chk("int count", 3, n_int);
		$display("static test done");
		mode <= wim_pkg::mode_sleep;
		sw_lvl[0] <= 1'b1;
		cyc(400);
		chk("wake count", 1, n_up);
		rd(8'h14, 32'h6);
		mode <= wim_pkg::mode_failsafe;
		sw_lvl[0] <= 1'b0;
		cyc(400);
		chk("wake count", 2, n_up);
		chk("int count", 3, n_int);
		rd(8'h0c, 32'h1);
		mode <= wim_pkg::mode_normal;
		wr(8'h0c, 32'h7);
		$display("sleep test done");
		sw_lvl[2] <= 1'b1;
		sw_on[2] <= 1'b1;
		wr(8'h08, 32'h24);
		sw_lvl[2] <= 1'b0;
		cyc(10);
		rd(8'h14, 32'h6);
		t_one <= 1'b1;
		cyc(4);
		t_one <= 1'b0;
		cyc(5);
		rd(8'h14, 32'h2);
		wr(8'h08, 32'h34);
		sw_lvl[2] <= 1'b1;
		t_one <= 1'b1;
		cyc(4);
		t_one <= 1'b0;
		cyc(5);
		rd(8'h14, 32'h2);
		t_two <= 1'b1;
		cyc(4);
		t_two <= 1'b0;
		cyc(5);
		rd(8'h14, 32'h6);
		$display("cyclic test done");
		wr(8'h00, 32'h1b);
		alt[1] <= 1'b1;
		cyc(200);
		alt[1] <= 1'b0;
		alt[0] <= 1'b1;
		cyc(400);
		rd(8'h10, 32'h1);
		wr(8'h10, 32'h3);
		rd(8'h10, 32'h0);
		$display("alt test done");
		// a frozen block must not count a held level as filter time
		n_mark = n_int;
		ce <= 1'b0;
		sw_lvl[0] <= 1'b1;
		cyc(400);
		chk("frozen int", n_mark, n_int);
		ce <= 1'b1;
		cyc(400);
		rd(8'h0c, 32'h1);
		wr(8'h0c, 32'h1);
		sw_lvl[0] <= 1'b0;
		cyc(400);
		rd(8'h0c, 32'h1);
		wr(8'h0c, 32'h1);
		$display("enable test done");
		wr(8'h04, 32'h3f);
		wr(8'h00, 32'h81);
		cyc(4);
		chk("switch", 1, msw);
		chk("pulls", 32'h20, 32'({pu, pd}));
		sw_lvl[0] <= 1'b1;
		cyc(400);
		rd(8'h0c, 32'h0);
		rd(8'h14, 32'h6);
		wr(8'h08, 32'h3c);
		rd(8'h08, 32'h3c);
		pulse_sleep;
		chk("fail count", 1, n_fail);
		chk("restart count", 1, n_rst);
		wr(8'h00, 32'h85);
		pulse_sleep;
		chk("fail count", 1, n_fail);
		mode <= wim_pkg::mode_stop;
		cyc(3);
		chk("switch", 0, msw);
		mode <= wim_pkg::mode_sleep;
		cyc(3);
		chk("switch", 0, msw);
		$display("measure test done");
		give_verdict;
	end
endmodule
